// *** include/ioc_regs.vh ***
// constants for the in-order commit stage
`ifndef IOC_REGS_VH
`define IOC_REGS_VH
`define IOC_SLOTS        4
`define IOC_THREADS      2
`define IOC_ROB_DEPTH    16
`define IOC_ROB_AW       4
`define IOC_DATA_W       64
`define IOC_GREG_AW      5
`define IOC_FREG_AW      7
`define IOC_FREG_BASE_AW 5
`define IOC_FREG_EXT_W   2
`define IOC_PC_W         64
`define IOC_PC_STEP      64'h0000000000000004
`define IOC_KIND_FIX     2'h0
`define IOC_KIND_FLT     2'h1
`define IOC_KIND_STORE   2'h2
`define IOC_KIND_NONE    2'h3
`endif

// *** logic/ioc_commit.v ***
// in-order commit stage with per-thread holding buffers and flush
// Operation
// - results held in per-thread buffers, kind kept per entry
// - retire in program order, update state then
// - at most four instructions retire per step
// - four general register writes per cycle
// - one thread per cycle, alternating each cycle while thread 1 is active
// - results invisible to software before retirement
// - pc, registers and memory updated together
// - flush discards all unretired work of the flushed thread any cycle
// - float register address widened by two bits
`timescale 1ns/100ps
`include "ioc_regs.vh"
module ioc_commit #(
   parameter DEPTH = `IOC_ROB_DEPTH,
   parameter AW    = `IOC_ROB_AW,
   parameter DW    = `IOC_DATA_W
) (
   input  wire                         CLOCK,
   input  wire                         RST,
   input  wire                         ISSUE_VALID,
   input  wire                         ISSUE_THREAD,
   input  wire [1:0]                   ISSUE_KIND,
   input  wire [`IOC_GREG_AW-1:0]      ISSUE_GREG,
   input  wire [`IOC_FREG_BASE_AW-1:0] ISSUE_FREG,
   input  wire [`IOC_FREG_EXT_W-1:0]   ISSUE_FREG_EXT,
   output wire                         ISSUE_READY,
   output wire [AW-1:0]                ISSUE_TAG,
   input  wire                         DONE_VALID,
   input  wire                         DONE_THREAD,
   input  wire [AW-1:0]                DONE_TAG,
   input  wire [DW-1:0]                DONE_DATA,
   input  wire [DW-1:0]                DONE_ADDR,
   input  wire                         FLUSH,
   input  wire                         FLUSH_THREAD,
   input  wire                         THREAD1_ACTIVE,
   output reg  [`IOC_SLOTS-1:0]        GREG_WE,
   output reg  [4*`IOC_GREG_AW-1:0]    GREG_WADDR,
   output reg  [4*DW-1:0]              GREG_WDATA,
   output reg  [`IOC_SLOTS-1:0]        FREG_WE,
   output reg  [4*`IOC_FREG_AW-1:0]    FREG_WADDR,
   output reg  [4*DW-1:0]              FREG_WDATA,
   output reg  [`IOC_SLOTS-1:0]        MEM_WE,
   output reg  [4*DW-1:0]              MEM_WADDR,
   output reg  [4*DW-1:0]              MEM_WDATA,
   output reg                          COMMIT_VALID,
   output reg                          COMMIT_THREAD,
   output reg  [2:0]                   COMMIT_COUNT,
   output reg  [`IOC_PC_W-1:0]         PC0,
   output reg  [`IOC_PC_W-1:0]         PC1
);
   // per-thread holding entries: kind, destination, result, done flag
   reg [1:0]                kind_r  [0:2*DEPTH-1];
   reg [`IOC_FREG_AW-1:0]   dest_r  [0:2*DEPTH-1];
   reg [DW-1:0]             data_r  [0:2*DEPTH-1];
   reg [DW-1:0]             addr_r  [0:2*DEPTH-1];
   reg [2*DEPTH-1:0]        busy_r;              // entry allocated
   reg [2*DEPTH-1:0]        done_r;              // result present
   reg [AW:0]               head_r  [0:1];       // oldest unretired
   reg [AW:0]               tail_r  [0:1];       // next free
   reg                      turn_r;              // thread allowed to retire
   reg [AW:0]               head_nxt;
   reg [2:0]                n_ret;               // entries retiring now
   reg                      stop;                // older entry incomplete
   reg [AW:0]               used;
   integer                  i;                   // slot loop, count
   integer                  j;                   // slot loop, writes
   integer                  k;                   // slot loop, release
   localparam [AW:0]        FULL = DEPTH;        // entries per thread
   wire [AW:0]              slot_ent [0:`IOC_SLOTS-1]; // thread and entry
   genvar                   g;

   // entry seen by each retire slot, oldest in slot 0
   generate
      for (g = 0; g < `IOC_SLOTS; g = g + 1) begin : g_slot
         localparam [AW-1:0] OFF = g;            // slot offset from head
         assign slot_ent[g] = {cthr, head_r[cthr][AW-1:0] + OFF};
      end
   endgenerate

   // thread that retires this cycle (alternates when both run)
   wire        cthr   = THREAD1_ACTIVE ? turn_r : 1'b0;
   wire [AW:0] itail  = tail_r[ISSUE_THREAD];
   wire [AW:0] ifill  = itail - head_r[ISSUE_THREAD];
   // a flushed thread takes no issue in the flush cycle
   assign ISSUE_READY = (ifill != FULL) &&
                        !(FLUSH && FLUSH_THREAD == ISSUE_THREAD);
   assign ISSUE_TAG   = itail[AW-1:0];
   wire   do_issue    = ISSUE_VALID && ISSUE_READY;

   // count the oldest contiguous completed entries, up to four
   always @* begin
      n_ret = 3'h0;
      stop  = 1'b0;
      used  = tail_r[cthr] - head_r[cthr];
      for (i = 0; i < `IOC_SLOTS; i = i + 1) begin
         if (!stop && (i < used) && done_r[slot_ent[i]]) begin
            n_ret = n_ret + 3'h1;
         end else begin
            stop = 1'b1;
         end
      end
      head_nxt = head_r[cthr] + {{(AW-2){1'b0}}, n_ret};
   end

   // retirement group: all architectural writes in one step
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         GREG_WE       <= 4'h0;
         GREG_WADDR    <= {4*`IOC_GREG_AW{1'b0}};
         GREG_WDATA    <= {4*DW{1'b0}};
         FREG_WE       <= 4'h0;
         FREG_WADDR    <= {4*`IOC_FREG_AW{1'b0}};
         FREG_WDATA    <= {4*DW{1'b0}};
         MEM_WE        <= 4'h0;
         MEM_WADDR     <= {4*DW{1'b0}};
         MEM_WDATA     <= {4*DW{1'b0}};
         COMMIT_VALID  <= 1'b0;
         COMMIT_THREAD <= 1'b0;
         COMMIT_COUNT  <= 3'h0;
         PC0           <= {`IOC_PC_W{1'b0}};
         PC1           <= {`IOC_PC_W{1'b0}};
         turn_r        <= 1'b0;
      end else begin
         turn_r <= THREAD1_ACTIVE ? ~turn_r : 1'b0;
         // nothing leaves for a thread being flushed this cycle
         if (FLUSH && FLUSH_THREAD == cthr) begin
            GREG_WE      <= 4'h0;
            FREG_WE      <= 4'h0;
            MEM_WE       <= 4'h0;
            COMMIT_VALID <= 1'b0;
            COMMIT_COUNT <= 3'h0;
         end else begin
            COMMIT_VALID  <= (n_ret != 3'h0);
            COMMIT_THREAD <= cthr;
            COMMIT_COUNT  <= n_ret;
            // program counter moves with the same group
            if (cthr)
               PC1 <= PC1 + `IOC_PC_STEP * n_ret;
            else
               PC0 <= PC0 + `IOC_PC_STEP * n_ret;
            for (j = 0; j < `IOC_SLOTS; j = j + 1) begin
               // slot write enables by kind, only for retiring slots
               GREG_WE[j] <= (j < n_ret) &&
                  kind_r[slot_ent[j]] == `IOC_KIND_FIX;
               FREG_WE[j] <= (j < n_ret) &&
                  kind_r[slot_ent[j]] == `IOC_KIND_FLT;
               MEM_WE[j]  <= (j < n_ret) &&
                  kind_r[slot_ent[j]] == `IOC_KIND_STORE;
               GREG_WADDR[j*`IOC_GREG_AW +: `IOC_GREG_AW] <=
                  dest_r[slot_ent[j]][`IOC_GREG_AW-1:0];
               FREG_WADDR[j*`IOC_FREG_AW +: `IOC_FREG_AW] <=
                  dest_r[slot_ent[j]];
               GREG_WDATA[j*DW +: DW] <= data_r[slot_ent[j]];
               FREG_WDATA[j*DW +: DW] <= data_r[slot_ent[j]];
               MEM_WDATA[j*DW +: DW]  <= data_r[slot_ent[j]];
               MEM_WADDR[j*DW +: DW]  <= addr_r[slot_ent[j]];
            end
         end
      end
   end

   // holding buffer bookkeeping: issue, completion, release, flush
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         busy_r    <= {2*DEPTH{1'b0}};
         done_r    <= {2*DEPTH{1'b0}};
         head_r[0] <= {(AW+1){1'b0}};
         head_r[1] <= {(AW+1){1'b0}};
         tail_r[0] <= {(AW+1){1'b0}};
         tail_r[1] <= {(AW+1){1'b0}};
      end else begin
         if (!(FLUSH && FLUSH_THREAD == cthr)) begin
            head_r[cthr] <= head_nxt;
            for (k = 0; k < `IOC_SLOTS; k = k + 1) begin
               if (k < n_ret) begin
                  busy_r[slot_ent[k]] <= 1'b0;
                  done_r[slot_ent[k]] <= 1'b0;
               end
            end
         end
         // result lands in its entry (kind fixed at issue)
         if (DONE_VALID && busy_r[{DONE_THREAD, DONE_TAG}] &&
             !(FLUSH && FLUSH_THREAD == DONE_THREAD)) begin
            done_r[{DONE_THREAD, DONE_TAG}] <= 1'b1;
         end
         if (do_issue) begin
            tail_r[ISSUE_THREAD] <= itail + {{AW{1'b0}}, 1'b1};
            busy_r[{ISSUE_THREAD, itail[AW-1:0]}] <= 1'b1;
            done_r[{ISSUE_THREAD, itail[AW-1:0]}] <= 1'b0;
         end
         // discard every unretired entry of the flushed thread
         if (FLUSH) begin
            tail_r[FLUSH_THREAD] <= head_r[FLUSH_THREAD];
            for (k = 0; k < DEPTH; k = k + 1) begin
               busy_r[FLUSH_THREAD*DEPTH + k] <= 1'b0;
               done_r[FLUSH_THREAD*DEPTH + k] <= 1'b0;
            end
         end
      end
   end

   // entry payload storage, no reset needed
   always @(posedge CLOCK) begin
      if (do_issue) begin
         kind_r[{ISSUE_THREAD, itail[AW-1:0]}] <= ISSUE_KIND;
         // float destination carries two extension bits
         dest_r[{ISSUE_THREAD, itail[AW-1:0]}] <=
            (ISSUE_KIND == `IOC_KIND_FLT) ?
            {ISSUE_FREG_EXT, ISSUE_FREG} :
            {2'h0, ISSUE_GREG};
      end
      if (DONE_VALID) begin
         data_r[{DONE_THREAD, DONE_TAG}] <= DONE_DATA;
         addr_r[{DONE_THREAD, DONE_TAG}] <= DONE_ADDR;
      end
   end
endmodule

// *** testbench/ioc_commit_checker.sv ***
// assertions watching the outputs of the in-order commit stage
`timescale 1ns/100ps
module ioc_commit_checker #(
   parameter DEPTH = 16,
   parameter AW    = 4,
   parameter DW    = 64
) (
   input wire        CLOCK,
   input wire        RST,
   input wire        THREAD1_ACTIVE,
   input wire [3:0]  GREG_WE,
   input wire [3:0]  FREG_WE,
   input wire [3:0]  MEM_WE,
   input wire        COMMIT_VALID,
   input wire        COMMIT_THREAD,
   input wire [2:0]  COMMIT_COUNT,
   input wire [63:0] PC0,
   input wire [63:0] PC1
);
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   wire [3:0] any_we = GREG_WE | FREG_WE | MEM_WE; // slots writing any state
   a_group_max_four: assert property (COMMIT_VALID |-> COMMIT_COUNT inside {[3'h1:3'h4]})
      else $error("commit group size out of range");
   a_writes_in_group: assert property (any_we != 4'h0 |-> COMMIT_VALID)
      else $error("state written outside a commit step");
   a_slots_in_count: assert property ((any_we >> COMMIT_COUNT) == 4'h0)
      else $error("write in a slot beyond the group size");
   a_one_target: assert property (((GREG_WE & FREG_WE) | (GREG_WE & MEM_WE) | (FREG_WE & MEM_WE)) == 4'h0)
      else $error("one slot written to two targets");
   a_pc_step: assert property (COMMIT_VALID && !COMMIT_THREAD |-> PC0 == $past(PC0) + {COMMIT_COUNT, 2'h0})
      else $error("program counter not advanced by group");
   a_pc1_step: assert property (COMMIT_VALID && COMMIT_THREAD |-> PC1 == $past(PC1) + {COMMIT_COUNT, 2'h0})
      else $error("second program counter not advanced by group");
   a_pc_hold: assert property (!COMMIT_VALID |-> $stable(PC0) && $stable(PC1))
      else $error("program counter moved without commit");
   a_thread_alternates: assert property ($past(THREAD1_ACTIVE) && $past(THREAD1_ACTIVE, 2) && COMMIT_VALID && $past(COMMIT_VALID) |-> COMMIT_THREAD != $past(COMMIT_THREAD))
      else $error("same thread committed on consecutive cycles");
   a_single_thread: assert property (!$past(THREAD1_ACTIVE) && COMMIT_VALID |-> !COMMIT_THREAD)
      else $error("second thread committed while inactive");
endmodule
bind ioc_commit ioc_commit_checker #(.DEPTH(DEPTH), .AW(AW), .DW(DW)) i_chk (.*);

// *** testbench/ioc_exec_model.sv ***
// execution pipes model: completes issued entries youngest first
`timescale 1ns/100ps
module ioc_exec_model (
   input  wire        clk,
   input  wire        rst,
   input  wire        issue_fire,
   input  wire        issue_thread,
   input  wire [3:0]  issue_tag,
   input  wire        flush,
   input  wire        go,
   output reg         done_valid,
   output reg         done_thread,
   output reg  [3:0]  done_tag,
   output reg  [63:0] done_data,
   output reg  [63:0] done_addr
);
   logic [4:0] pend_q[$]; // thread and tag of entries still executing
   // one completion a cycle while go is high; idle data keeps toggling
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_q.delete();
         done_valid <= 1'b0;
         {done_thread, done_tag, done_data, done_addr} <= '0;
      end else begin
         done_valid <= go && pend_q.size() != 0;
         if (go && pend_q.size() != 0) begin
            {done_thread, done_tag} <= pend_q[$];
            done_data <= 64'hA0 + pend_q[$][3:0];
            done_addr <= 64'h100 + pend_q[$][3:0];
            pend_q.pop_back();
         end else begin
            done_data <= ~done_data;
            done_addr <= ~done_addr;
         end
         if (flush) pend_q.delete(); // flushed work never completes
         else if (issue_fire) pend_q.push_back({issue_thread, issue_tag});
      end
   end
endmodule

// *** testbench/ioc_commit_tb.sv ***
// self-checking bench for the in-order commit stage
`timescale 1ns/100ps
module ioc_commit_tb;
   reg         CLOCK = 1'b0, RST = 1'b1, ISSUE_VALID = 1'b0, ISSUE_THREAD = 1'b0;
   reg         FLUSH = 1'b0, FLUSH_THREAD = 1'b0, THREAD1_ACTIVE = 1'b0, go = 1'b0;
   reg  [1:0]  ISSUE_KIND = 2'h0, ISSUE_FREG_EXT = 2'h0;
   reg  [4:0]  ISSUE_GREG = 5'h00, ISSUE_FREG = 5'h00;
   wire        ISSUE_READY, COMMIT_VALID, COMMIT_THREAD, DONE_VALID, DONE_THREAD;
   wire [3:0]  ISSUE_TAG, DONE_TAG, GREG_WE, FREG_WE, MEM_WE;
   wire [19:0] GREG_WADDR;
   wire [27:0] FREG_WADDR;
   wire [255:0] GREG_WDATA, FREG_WDATA, MEM_WADDR, MEM_WDATA;
   wire [63:0] DONE_DATA, DONE_ADDR, PC0, PC1;
   wire [2:0]  COMMIT_COUNT;
   int         failures = 0, total_checks = 0;
   logic [12:0] exp_q[2][$]; // per-thread tag, kind and address in order
   logic [3:0] next_tag[2] = '{4'h0, 4'h0}; // entry each thread issues next
   // kind and destination of the single-thread program, in order
   localparam logic [8:0] ORD[8] = '{9'h001, 9'h002, 9'h0E5, 9'h100,
                                     9'h180, 9'h003, 9'h004, 9'h005};
   ioc_commit i_dut (.*);
   ioc_exec_model i_exec (.clk(CLOCK), .rst(RST), .issue_fire(ISSUE_VALID && ISSUE_READY),
      .issue_thread(ISSUE_THREAD), .issue_tag(ISSUE_TAG), .flush(FLUSH), .go(go),
      .done_valid(DONE_VALID), .done_thread(DONE_THREAD), .done_tag(DONE_TAG),
      .done_data(DONE_DATA), .done_addr(DONE_ADDR));
   always #2 CLOCK = ~CLOCK;
   task automatic chk(input string what, input logic [63:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic match(input logic [8:0] got, input logic [63:0] dat, adr, input logic mem);
      logic [12:0] e;
      e = exp_q[COMMIT_THREAD].size() ? exp_q[COMMIT_THREAD].pop_front() : 13'h1FFF;
      chk("write", e[8:0], got);
      chk("data", 64'hA0 + e[12:9], dat);
      if (mem) chk("addr", 64'h100 + e[12:9], adr);
   endtask
   // follow every architectural write in slot order
   always @(negedge CLOCK) begin
      for (int i = 0; i < 4; i++) begin
         if (GREG_WE[i] === 1'b1) match({4'h0, GREG_WADDR[i*5 +: 5]}, GREG_WDATA[i*64 +: 64], 64'h0, 1'b0);
         if (FREG_WE[i] === 1'b1) match({2'h1, FREG_WADDR[i*7 +: 7]}, FREG_WDATA[i*64 +: 64], 64'h0, 1'b0);
         if (MEM_WE[i] === 1'b1) match(9'h100, MEM_WDATA[i*64 +: 64], MEM_WADDR[i*64 +: 64], 1'b1);
      end
   end
   task automatic iss(input logic t, input logic [1:0] k, input logic [6:0] r, input logic keep);
      @(posedge CLOCK);
      ISSUE_VALID <= 1'b1;
      ISSUE_THREAD <= t;
      ISSUE_KIND <= k;
      ISSUE_GREG <= r[4:0];
      ISSUE_FREG <= r[4:0];
      ISSUE_FREG_EXT <= r[6:5];
      if (keep && k != 2'h3) exp_q[t].push_back({next_tag[t], k, k == 2'h1 ? r : {2'h0, r[4:0]}});
      next_tag[t]++;
   endtask
   task automatic drain(input string name, input logic [63:0] pc0, pc1);
      @(posedge CLOCK);
      ISSUE_VALID <= 1'b0;
      go <= 1'b1;
      for (int n = 0; n < 40 && exp_q[0].size() + exp_q[1].size() != 0; n++) @(posedge CLOCK);
      repeat (4) @(posedge CLOCK);
      go <= 1'b0;
      @(negedge CLOCK);
      chk("pc0", pc0, PC0);
      chk("pc1", pc1, PC1);
      chk("pending", 64'h0, exp_q[0].size() + exp_q[1].size());
      $display("test %s done", name);
   endtask
   task automatic t_order;
      for (int i = 0; i < 8; i++) iss(1'b0, ORD[i][8:7], ORD[i][6:0], 1'b1);
      @(posedge CLOCK);
      ISSUE_VALID <= 1'b0;
      repeat (3) @(negedge CLOCK);
      chk("pc0 early", 64'h0, PC0);
      drain("order", 64'h20, 64'h0);
   endtask
   task automatic t_flush;
      iss(1'b0, 2'h0, 7'h08, 1'b0);
      iss(1'b0, 2'h0, 7'h09, 1'b0);
      @(posedge CLOCK);
      ISSUE_VALID <= 1'b0;
      FLUSH <= 1'b1;
      @(posedge CLOCK);
      FLUSH <= 1'b0;
      next_tag[0] = PC0[5:2]; // flushed entries are handed out again
      iss(1'b0, 2'h0, 7'h0A, 1'b1);
      drain("flush", 64'h24, 64'h0);
   endtask
   task automatic t_smt;
      @(posedge CLOCK);
      THREAD1_ACTIVE <= 1'b1;
      iss(1'b1, 2'h0, 7'h0B, 1'b1);
      iss(1'b0, 2'h0, 7'h0C, 1'b1);
      iss(1'b1, 2'h1, 7'h53, 1'b1);
      drain("threads", 64'h28, 64'h8);
   endtask
   task automatic conclude;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge CLOCK);
      RST <= 1'b0;
      t_order;
      t_flush;
      t_smt;
      conclude;
   end
   initial begin
      repeat (2000) @(posedge CLOCK);
      failures++;
      conclude;
   end
endmodule
